// [fpec_ctrl.sv]
// flash program/erase sequencer: register file, command state machine, dma and stall outputs
// assumes a synchronous special function register port and one clock with clock enable
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defines.svh"

module fpec_ctrl #(
  parameter int          NUM_PAGES   = 32,
  parameter logic [15:0] ERASE_STEPS = 16'(`FPEC_ERASE_STEPS)
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // special function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // power management and cpu
  input  wire logic       deep_sleep_exit_i,
  input  wire logic       exec_from_flash_i,
  output logic            fetch_stall_o,
  input  wire logic [14:0] fetch_addr_i,
  output logic      [7:0] fetch_data_o,
  // dma and read mode
  output logic            dma_trigger_o,
  output logic            continuous_read_enable_o
);
  import fpec_pkg::*;

  fpec_flash_if fif ();

  fpec_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .tif   (fif.tmr)
  );

  fpec_flash_array #(
    .NUM_PAGES (NUM_PAGES)
  ) u_array (
    .clk_i (clk_i),
    .ce_i  (ce_i),
    .fif   (fif.array)
  );

  // registers
  fpec_state_t state_q;
  fpec_state_t state_d;
  logic [5:0]  timing_q;
  logic [7:0]  low_addr_q;
  logic [7:0]  high_addr_q;
  logic [7:0]  write_byte_q;
  logic [7:0]  low_byte_q;
  logic        have_low_q;
  logic        continuous_read_enable_q;
  logic        write_pend_q;
  logic        erase_then_write_q;
  logic [7:0]  rdata_q;
  logic        fetch_hi_q;
  logic        dma_q;

  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // one select per register, shared by the write strobes and the read mux
  logic sel_timing_w;
  logic sel_low_w;
  logic sel_high_w;
  logic sel_cmd_w;
  logic sel_byte_w;
  logic erasing_w;
  logic programming_w;
  logic wr_timing_w;
  logic wr_low_w;
  logic wr_high_w;
  logic wr_cmd_w;
  logic wr_byte_w;
  logic cmd_write_w;
  logic cmd_erase_w;
  logic idle_w;
  logic armed_w;
  logic byte_taken_w;
  logic pair_done_w;
  logic timeout_w;
  logic prog_done_w;
  logic erase_done_w;
  logic start_erase_w;
  logic start_arm_w;
  logic busy_w;
  logic [13:0] word_addr_w;
  logic [13:0] next_addr_w;
  logic [7:0]  cmd_read_w;

  assign sel_timing_w = hit(sfr_addr_i, `FPEC_OFS_TIMING);
  assign sel_low_w    = hit(sfr_addr_i, `FPEC_OFS_LOW_ADDR);
  assign sel_high_w   = hit(sfr_addr_i, `FPEC_OFS_HIGH_ADDR);
  assign sel_cmd_w    = hit(sfr_addr_i, `FPEC_OFS_CMD_STAT);
  assign sel_byte_w   = hit(sfr_addr_i, `FPEC_OFS_WRITE_BYTE);

  assign wr_timing_w = sfr_wr_i && sel_timing_w;
  assign wr_low_w    = sfr_wr_i && sel_low_w;
  assign wr_high_w   = sfr_wr_i && sel_high_w;
  assign wr_cmd_w    = sfr_wr_i && sel_cmd_w;
  assign wr_byte_w   = sfr_wr_i && sel_byte_w;

  // a control write may carry both command bits; erase goes first and write waits for it
  assign cmd_write_w = wr_cmd_w && sfr_wdata_i[`FPEC_BIT_WRITE];
  assign cmd_erase_w = wr_cmd_w && sfr_wdata_i[`FPEC_BIT_ERASE];

  assign idle_w        = (state_q == FPEC_IDLE);
  assign armed_w       = (state_q == FPEC_ARMED);
  assign erasing_w     = (state_q == FPEC_ERASE);
  assign programming_w = (state_q == FPEC_PROG);
  // busy covers the erase, the armed wait for a pair and the word write itself
  assign busy_w        = !idle_w;

  // commands are taken only when idle; a repeated write while armed changes nothing
  assign start_erase_w = idle_w && cmd_erase_w && !deep_sleep_exit_i;
  assign start_arm_w   = idle_w && cmd_write_w && !cmd_erase_w && !deep_sleep_exit_i;

  // a data byte counts toward a pair only while armed and not programming
  assign byte_taken_w = wr_byte_w && armed_w;
  assign pair_done_w  = byte_taken_w && have_low_q;

  // a pair that lands in the last cycle of the wait still wins over the timeout
  assign timeout_w    = armed_w && fif.tmr_done && !pair_done_w;
  assign prog_done_w  = programming_w && fif.tmr_done;
  assign erase_done_w = erasing_w && fif.tmr_done;

  // word address: page in high bits 5:1, word index in high bit 0 and the low byte
  assign word_addr_w = {high_addr_q[5:0], low_addr_q};
  assign next_addr_w = word_addr_w + 14'h0001;

  // write and erase bits are commands only and always read back as zero
  assign cmd_read_w = {busy_w, write_pend_q, 1'b0, continuous_read_enable_q, 2'b00, 1'b0, 1'b0};

  // idle -> erase -> idle, or on to armed when write came with the erase
  // idle -> armed -> prog -> armed ... until the pair timeout drops back to idle
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      FPEC_IDLE: begin
        if (start_erase_w) begin
          state_d = FPEC_ERASE;
        end else if (start_arm_w) begin
          state_d = FPEC_ARMED;
        end
      end
      FPEC_ERASE: begin
        if (erase_done_w) begin
          state_d = erase_then_write_q ? FPEC_ARMED : FPEC_IDLE;
        end
      end
      FPEC_ARMED: begin
        if (pair_done_w) begin
          state_d = FPEC_PROG;
        end else if (timeout_w) begin
          state_d = FPEC_IDLE;
        end
      end
      FPEC_PROG: begin
        if (prog_done_w) begin
          state_d = FPEC_ARMED;
        end
      end
      default: begin
        state_d = FPEC_IDLE;
      end
    endcase
    // leaving a deep sleep mode abandons any command
    if (deep_sleep_exit_i) begin
      state_d = FPEC_IDLE;
    end
  end

  // timing generator requests: every entry into a timed state restarts it
  // erase, word write and pair timeout never overlap, so one counter serves
  // all three and saves a second prescaler
  logic        enter_erase_w;
  logic        enter_armed_w;
  logic        enter_prog_w;
  fpec_steps_t steps_w;

  assign enter_erase_w = (state_d == FPEC_ERASE) && !erasing_w;
  assign enter_armed_w = (state_d == FPEC_ARMED) && !armed_w;
  assign enter_prog_w  = (state_d == FPEC_PROG) && !programming_w;

  assign steps_w = enter_erase_w ? ERASE_STEPS :
                   enter_prog_w  ? 16'(`FPEC_PROG_STEPS) :
                                   16'(`FPEC_TIMEOUT_STEPS);

  assign fif.tmr_start = enter_erase_w || enter_armed_w || enter_prog_w;
  assign fif.tmr_steps = steps_w;
  assign fif.tmr_field = timing_q;

  // flash array requests
  // the second byte goes straight to the array beside the held first byte,
  // so the word is written in the very cycle the pair completes
  assign fif.erase_req  = enter_erase_w && ce_i;
  assign fif.erase_page = high_addr_q[`FPEC_PAGE_MSB:`FPEC_PAGE_LSB];
  assign fif.prog_req   = pair_done_w && ce_i;
  assign fif.word_addr  = word_addr_w;
  assign fif.word_data  = {sfr_wdata_i, low_byte_q};
  assign fif.rd_addr    = fetch_addr_i[14:1];

  // state and command bookkeeping
  // the pair phase restarts on every arming, so a half pair left by a timeout
  // cannot shift the bytes of the next command
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q            <= FPEC_IDLE;
      erase_then_write_q <= 1'b0;
      have_low_q         <= 1'b0;
      write_pend_q       <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      if (start_erase_w) begin
        erase_then_write_q <= cmd_write_w;
      end
      if (enter_armed_w || state_d == FPEC_IDLE) begin
        have_low_q <= 1'b0;
      end else if (byte_taken_w) begin
        have_low_q <= !have_low_q;
      end
      write_pend_q <= (state_d == FPEC_PROG);
    end
  end

  // software registers; the address also advances after each programmed word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timing_q     <= `FPEC_RST_TIMING;
      low_addr_q   <= `FPEC_RST_ADDR;
      high_addr_q  <= `FPEC_RST_ADDR;
      write_byte_q <= `FPEC_RST_DATA;
      low_byte_q   <= `FPEC_RST_DATA;
      continuous_read_enable_q     <= 1'b0;
    end else if (ce_i) begin
      // the field is used live: changing it mid-operation stretches or shortens
      // the step in progress, so software should set it while idle
      if (wr_timing_w) begin
        timing_q <= sfr_wdata_i[5:0];
      end
      // the carry stops at bit 5, so a run past the last page wraps to page 0
      if (prog_done_w) begin
        low_addr_q  <= next_addr_w[7:0];
        high_addr_q <= {high_addr_q[7:6], next_addr_w[13:8]};
      end else begin
        if (wr_low_w) begin
          low_addr_q <= sfr_wdata_i;
        end
        if (wr_high_w) begin
          high_addr_q <= sfr_wdata_i;
        end
      end
      // writes during word programming are ignored rather than corrupting the pair
      if (wr_byte_w && !write_pend_q) begin
        write_byte_q <= sfr_wdata_i;
      end
      if (byte_taken_w && !have_low_q) begin
        low_byte_q <= sfr_wdata_i;
      end
      if (wr_cmd_w) begin
        continuous_read_enable_q <= sfr_wdata_i[`FPEC_BIT_CONTINUOUS_READ_ENABLE];
      end
    end
  end

  // read data, fetch data and dma request come from flip-flops
  logic [7:0] rd_mux_w;
  logic       dma_d;

  // unmapped addresses read as zero
  assign rd_mux_w = sel_timing_w ? {2'b00, timing_q} :
                    sel_low_w    ? low_addr_q :
                    sel_high_w   ? high_addr_q :
                    sel_cmd_w    ? cmd_read_w :
                    sel_byte_w   ? write_byte_q :
                                   8'h00;

  // first request on arming, then whenever the data register can take another byte
  assign dma_d = enter_armed_w ||
                 (byte_taken_w && !have_low_q) ||
                 prog_done_w;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q      <= 8'h00;
      fetch_hi_q   <= 1'b0;
      dma_q        <= 1'b0;
    end else if (ce_i) begin
      rdata_q    <= rd_mux_w;
      fetch_hi_q <= fetch_addr_i[0];
      // no request when heading for idle: there is no command left to feed
      dma_q      <= dma_d && (state_d != FPEC_IDLE);
    end
  end

  // byte select lags the array read by one cycle, matching its registered output
  assign fetch_data_o = fetch_hi_q ? fif.rd_data[15:8] : fif.rd_data[7:0];

  assign sfr_rdata_o              = rdata_q;
  assign dma_trigger_o            = dma_q;
  assign continuous_read_enable_o = continuous_read_enable_q;
  // fetches from flash cannot proceed while the array is being written
  // kept combinational so a fetch meeting a freshly started command waits at once
  assign fetch_stall_o            = exec_from_flash_i && busy_w;

endmodule

`default_nettype wire

// [fpec_defines.svh]
// register offsets, field positions, reset values and timing figures of the flash sequencer
// assumes inclusion by bare name from the package and the design modules
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// register offsets on the special function register port
`define FPEC_OFS_TIMING     8'hAB
`define FPEC_OFS_LOW_ADDR   8'hAC
`define FPEC_OFS_HIGH_ADDR  8'hAD
`define FPEC_OFS_CMD_STAT   8'hAE
`define FPEC_OFS_WRITE_BYTE 8'hAF

// command and status field positions
`define FPEC_BIT_BUSY       7
`define FPEC_BIT_SWBUSY     6
`define FPEC_BIT_CONTINUOUS_READ_ENABLE     4
`define FPEC_BIT_WRITE      1
`define FPEC_BIT_ERASE      0
`define FPEC_PAGE_MSB       5
`define FPEC_PAGE_LSB       1

// reset values
`define FPEC_RST_TIMING     6'h11
`define FPEC_RST_ADDR       8'h00
`define FPEC_RST_DATA       8'h00

// word geometry
`define FPEC_WORDS_PER_PAGE 512
`define FPEC_ERASED_WORD    16'hFFFF

// the timing generator steps once per timing-field cycles, i.e. 21000/16 ns per step
`define FPEC_STEP_PS        1312500
`define FPEC_PROG_PS        20000000
`define FPEC_TIMEOUT_PS     40000000
`define FPEC_ERASE_US       20000
// least times round up, the upper limit (timeout) rounds down
`define FPEC_PROG_STEPS     ((`FPEC_PROG_PS + `FPEC_STEP_PS - 1) / `FPEC_STEP_PS)
`define FPEC_TIMEOUT_STEPS  (`FPEC_TIMEOUT_PS / `FPEC_STEP_PS)
`define FPEC_ERASE_STEPS    ((64'd`FPEC_ERASE_US * 64'd1000000 + 64'd`FPEC_STEP_PS - 64'd1) / 64'd`FPEC_STEP_PS)

`endif

// [fpec_pkg.sv]
// types shared by the flash sequencer modules
// assumes fpec_defines.svh is on the include path
package fpec_pkg;
  `include "fpec_defines.svh"

  typedef enum logic [3:0] {
    FPEC_IDLE  = 4'b0001,
    FPEC_ERASE = 4'b0010,
    FPEC_ARMED = 4'b0100,
    FPEC_PROG  = 4'b1000
  } fpec_state_t;

  typedef logic [13:0] fpec_word_addr_t;
  typedef logic [15:0] fpec_word_t;
  typedef logic [15:0] fpec_steps_t;
endpackage

// [fpec_flash_if.sv]
// bundle between the sequencer, its timing generator and the flash array
// assumes one clock domain; no clocking block
`timescale 1ns/100ps
`default_nettype none

interface fpec_flash_if;
  import fpec_pkg::*;
  logic            prog_req;
  logic            erase_req;
  fpec_word_addr_t word_addr;
  fpec_word_t      word_data;
  logic [4:0]      erase_page;
  logic [13:0]     rd_addr;
  fpec_word_t      rd_data;
  logic            tmr_start;
  fpec_steps_t     tmr_steps;
  logic [5:0]      tmr_field;
  logic            tmr_done;

  modport ctrl  (output prog_req, erase_req, word_addr, word_data, erase_page, rd_addr,
                 tmr_start, tmr_steps, tmr_field,
                 input  rd_data, tmr_done);
  modport array (input  prog_req, erase_req, word_addr, word_data, erase_page, rd_addr,
                 output rd_data);
  modport tmr   (input  tmr_start, tmr_steps, tmr_field,
                 output tmr_done);
endinterface

`default_nettype wire

// [fpec_timer.sv]
// program/erase timing generator: steps every timing-field cycles, pulses done after N steps
// assumes start is a one-cycle pulse; a new start restarts the count
`timescale 1ns/100ps
`default_nettype none

module fpec_timer (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // control
  fpec_flash_if.tmr tif
);
  import fpec_pkg::*;

  logic [5:0]  pre_q;
  fpec_steps_t cnt_q;
  logic        run_q;
  logic        step_w;
  logic        last_w;

  // a zero field already steps every cycle, so it is treated as one cycle per step
  assign step_w = (pre_q + 6'h01 >= tif.tmr_field) || (tif.tmr_field == 6'h00);
  assign last_w = step_w && (cnt_q + 16'h0001 >= tif.tmr_steps);
  assign tif.tmr_done = run_q && last_w && ce_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 6'h00;
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (ce_i) begin
      if (tif.tmr_start) begin
        pre_q <= 6'h00;
        cnt_q <= 16'h0000;
        run_q <= 1'b1;
      end else if (run_q) begin
        pre_q <= step_w ? 6'h00 : pre_q + 6'h01;
        cnt_q <= step_w ? cnt_q + 16'h0001 : cnt_q;
        run_q <= !last_w;
      end
    end
  end
endmodule

`default_nettype wire

// [fpec_flash_array.sv]
// embedded flash word array: program only clears bits, page erase sets the page to ones
// assumes the sequencer never programs and erases in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defines.svh"

module fpec_flash_array #(
  parameter int NUM_PAGES = 32
) (
  // clock and enable
  input  wire logic clk_i,
  input  wire logic ce_i,
  // sequencer side
  fpec_flash_if.array fif
);
  import fpec_pkg::*;

  localparam int WORDS = NUM_PAGES * `FPEC_WORDS_PER_PAGE;

  fpec_word_t mem [0:WORDS-1];
  fpec_word_t rd_q;

  assign fif.rd_data = rd_q;

  // contents are not reset: flash keeps its data across a chip reset
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (fif.erase_req) begin
        for (int i = 0; i < `FPEC_WORDS_PER_PAGE; i++) begin
          mem[(int'(fif.erase_page) * `FPEC_WORDS_PER_PAGE + i) % WORDS] <= `FPEC_ERASED_WORD;
        end
      end else if (fif.prog_req) begin
        mem[int'(fif.word_addr) % WORDS] <= mem[int'(fif.word_addr) % WORDS] & fif.word_data;
      end
      rd_q <= mem[int'(fif.rd_addr) % WORDS];
    end
  end
endmodule

`default_nettype wire

// [fpec_ctrl_props.sv]
// concurrent checks on the flash sequencer's top-level ports
// assumes one clock, clk_i, with rst_i asynchronous and active high
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defines.svh"

module fpec_ctrl_props (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // observed ports
  input wire logic       ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       deep_sleep_exit_i,
  input wire logic       exec_from_flash_i,
  input wire logic       fetch_stall_o,
  input wire logic       dma_trigger_o,
  input wire logic       continuous_read_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // busy is only visible through the stall while the cpu runs from flash
  wire idle   = exec_from_flash_i && !fetch_stall_o;
  wire ctl_wr = ce_i && sfr_wr_i && (sfr_addr_i == `FPEC_OFS_CMD_STAT);
  wire dat_wr = ce_i && sfr_wr_i && (sfr_addr_i == `FPEC_OFS_WRITE_BYTE);
  wire ctl_rd = (sfr_addr_i == `FPEC_OFS_CMD_STAT) && ce_i;
  wire wd4    = sfr_wdata_i[4];
  wire ers_go = ctl_wr && idle && sfr_wdata_i[0] && !deep_sleep_exit_i;

  stall_gated_a: assert property (!exec_from_flash_i |-> !fetch_stall_o)
    else $error("stall without flash fetch");
  arm_dma_req_a: assert property (ctl_wr && idle && sfr_wdata_i[1:0] == 2'b10 |=> dma_trigger_o)
    else $error("no dma request after arming");
  dma_one_pulse_a: assert property (dma_trigger_o |=> !dma_trigger_o)
    else $error("dma request longer than one cycle");
  cmd_sets_busy_a: assert property (ctl_wr && idle && sfr_wdata_i[1:0] != 2'b00 |=> fetch_stall_o)
    else $error("command did not stall fetch");
  // a sleep exit may abort the erase, so only runs without one are held to length
  erase_holds_busy_a: assert property (ers_go ##1 !deep_sleep_exit_i [*3]
    |-> fetch_stall_o)
    else $error("erase ended too early");
  ctl_zero_bits_a: assert property ($past(ctl_rd) |-> (sfr_rdata_o & 8'h2F) == 8'h00)
    else $error("control read shows nonzero fixed bits");
  pend_busy_a: assert property ($past(ctl_rd) |-> !sfr_rdata_o[6] || sfr_rdata_o[7])
    else $error("word pending without busy");
  cre_store_a: assert property (ctl_wr |=> continuous_read_enable_o == $past(wd4))
    else $error("continuous read bit not stored");
  sleep_idle_a: assert property (ce_i && deep_sleep_exit_i |=> !fetch_stall_o)
    else $error("sleep exit did not abort");
  idle_store_a: assert property (dat_wr && idle |=> !fetch_stall_o && !dma_trigger_o)
    else $error("idle data write started work");

  arm_erase_c: cover property (ctl_wr && idle && sfr_wdata_i[1:0] == 2'b11);
  sleep_abort_c: cover property (deep_sleep_exit_i && fetch_stall_o);
  dma_req_c: cover property (dma_trigger_o);
endmodule

bind fpec_ctrl fpec_ctrl_props u_props (.clk_i, .rst_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rdata_o, .deep_sleep_exit_i, .exec_from_flash_i, .fetch_stall_o,
  .dma_trigger_o, .continuous_read_enable_o);

`default_nettype wire

// [fpec_dma_model.sv]
// dma channel model: answers each flash request with one byte write to the data register while q holds a byte
// assumes the bench fills q and multiplexes the register port while wr_o is high
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defines.svh"

module fpec_dma_model (
  // clock and request
  input  wire logic       clk_i,
  input  wire logic       req_i,
  // register port
  output logic            wr_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] data_o
);
  logic [7:0] q[$];

  initial begin
    wr_o   = 1'b0;
    addr_o = 8'h00;
    data_o = 8'h5A;
  end

  // writes only on request, so never while a word is pending
  always @(posedge clk_i) begin
    if (req_i && q.size() > 0) begin
      #1;
      wr_o   = 1'b1;
      addr_o = `FPEC_OFS_WRITE_BYTE;
      data_o = q.pop_front();
      @(posedge clk_i);
      #1;
      wr_o   = 1'b0;
      addr_o = ~addr_o;
      data_o = ~data_o;
    end
  end
endmodule

`default_nettype wire

// [flash_program_erase_ctrl_tb.sv]
// self-checking bench for the flash sequencer with a dma partner
// assumes erase shortened to 4 steps and the timing field set to one cycle per step
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defines.svh"

module flash_program_erase_ctrl_tb;
  logic        clk_i, rst_i, ce_i, tb_wr, deep_sleep_exit_i, exec_from_flash_i;
  logic [7:0]  tb_addr, tb_wdata, sfr_rdata_o, fetch_data_o, d_addr, d_data;
  logic        d_wr, fetch_stall_o, dma_trigger_o, cre_o;
  logic [14:0] fetch_addr_i;
  logic [7:0]  v;
  logic [13:0] w0;
  logic [15:0] a, b, x, wv[8];
  int          n, checks, n_fail;
  // the dma model owns the port only while it strobes
  wire         sfr_wr_i    = tb_wr | d_wr;
  wire [7:0]   sfr_addr_i  = d_wr ? d_addr : tb_addr;
  wire [7:0]   sfr_wdata_i = d_wr ? d_data : tb_wdata;

  fpec_ctrl #(.NUM_PAGES(32), .ERASE_STEPS(16'h0004)) dut (.clk_i, .rst_i, .ce_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .deep_sleep_exit_i,
    .exec_from_flash_i, .fetch_stall_o, .fetch_addr_i, .fetch_data_o, .dma_trigger_o,
    .continuous_read_enable_o(cre_o));
  fpec_dma_model u_dma (.clk_i, .req_i(dma_trigger_o), .wr_o(d_wr), .addr_o(d_addr),
    .data_o(d_data));

  always #2 clk_i = ~clk_i;

  function automatic logic [15:0] after_prog(logic [15:0] old, logic [15:0] nw);
    return old & nw;
  endfunction

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk_i);
    #1 tb_wr = 1'b1;
    tb_addr = ad;
    tb_wdata = d;
    @(posedge clk_i);
    #1 tb_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, output logic [7:0] r);
    @(posedge clk_i);
    #1 tb_addr = ad;
    @(posedge clk_i);
    #1 r = sfr_rdata_o;
  endtask
  task automatic fetch(logic [13:0] w, output logic [15:0] r);
    @(posedge clk_i);
    #1 fetch_addr_i = {w, 1'b0};
    @(posedge clk_i);
    #1 r[7:0] = fetch_data_o;
    fetch_addr_i = {w, 1'b1};
    @(posedge clk_i);
    #1 r[15:8] = fetch_data_o;
  endtask
  task automatic set_addr(logic [13:0] w);
    wr(`FPEC_OFS_HIGH_ADDR, {2'b00, w[13:8]});
    wr(`FPEC_OFS_LOW_ADDR, w[7:0]);
  endtask
  task automatic prog_pair(logic [15:0] d);
    wr(`FPEC_OFS_WRITE_BYTE, d[7:0]);
    wr(`FPEC_OFS_WRITE_BYTE, d[15:8]);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (fetch_stall_o !== 1'b0 && k < 500) begin
      @(posedge clk_i);
      #1 k++;
    end
    check("idle", 16'(k >= 500), 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #80000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    clk_i = 0; rst_i = 1; ce_i = 1; tb_wr = 0; tb_addr = 0; tb_wdata = 0;
    deep_sleep_exit_i = 0; exec_from_flash_i = 1; fetch_addr_i = 0; checks = 0; n_fail = 0;
    void'($urandom(34));
    repeat (16) @(posedge clk_i);
    #1 rst_i = 0;
    rd(`FPEC_OFS_TIMING, v); check("timing", 16'(v[5:0]), 16'h0011);
    rd(`FPEC_OFS_CMD_STAT, v); check("ctrl", 16'(v), 16'h0000);
    for (int r = 'hAC; r <= 'hAF; r += 3) begin
      rd(8'(r), v); check("addr_data", 16'(v), 16'h0000);
    end
    wr(`FPEC_OFS_CMD_STAT, 8'h10); rd(`FPEC_OFS_CMD_STAT, v);
    check("continuous_read_enable", {v, 7'h00, cre_o}, 16'h1001);
    wr(`FPEC_OFS_CMD_STAT, 8'h00);
    ce_i = 1'b0;
    wr(`FPEC_OFS_CMD_STAT, 8'h10);
    ce_i = 1'b1;
    check("ce_freeze", 16'(cre_o), 16'h0000);
    wr(`FPEC_OFS_WRITE_BYTE, 8'hA5); rd(`FPEC_OFS_WRITE_BYTE, v);
    check("idle_data", {v, 7'h00, fetch_stall_o}, 16'hA500);
    wr(`FPEC_OFS_TIMING, 8'h01);
    w0 = {5'($urandom_range(31, 0)), 9'($urandom_range(500, 0))};
    n = $urandom_range(5, 2);
    for (int i = 0; i < n; i++) begin
      wv[i] = 16'($urandom);
      u_dma.q.push_back(wv[i][7:0]);
      u_dma.q.push_back(wv[i][15:8]);
    end
    set_addr(w0);
    wr(`FPEC_OFS_CMD_STAT, 8'h03);
    rd(`FPEC_OFS_CMD_STAT, v); check("cmd_read", 16'(v[1:0]), 16'h0000);
    wait_idle();
    rd(`FPEC_OFS_LOW_ADDR, v); check("fail_lo", 16'(v), 16'(8'(w0 + 14'(n))));
    x = 16'(w0 + 14'(n));
    rd(`FPEC_OFS_HIGH_ADDR, v); check("fail_hi", 16'(v), 16'(x[13:8]));
    for (int i = 0; i < n; i++) begin
      fetch(w0 + 14'(i), x); check("dma_word", x, wv[i]);
    end
    fetch({w0[13:9], 9'h1FF}, x); check("erased", x, `FPEC_ERASED_WORD);
    a = 16'($urandom) & 16'h7FFE;
    wr(`FPEC_OFS_CMD_STAT, 8'h02);
    prog_pair(a);
    rd(`FPEC_OFS_CMD_STAT, v); check("pending", 16'(v[7:6]), 16'h0003);
    wait_idle();
    fetch(w0 + 14'(n), x); check("resume", x, a);
    b = 16'($urandom) | 16'h8001;
    set_addr(w0 + 14'(n));
    wr(`FPEC_OFS_CMD_STAT, 8'h02);
    prog_pair(b);
    wait_idle();
    fetch(w0 + 14'(n), x); check("clear_only", x, after_prog(a, b));
    for (int c = 1; c < 3; c++) begin
      wr(`FPEC_OFS_CMD_STAT, 8'(c));
      @(posedge clk_i);
      #1 deep_sleep_exit_i = 1'b1;
      @(posedge clk_i);
      #1 deep_sleep_exit_i = 1'b0;
      rd(`FPEC_OFS_CMD_STAT, v); check("sleep_exit", 16'(v), 16'h0000);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
